// ===== core/redriver_power_and_rxdetect_ctrl.sv
// Per-channel power override and receiver-detect reset registers behind an SMBus/I2C slave.
// Assumes scl/sda, the power-down pin and the strap arrive asynchronously from the board.
//
// Behaviour
// - Override bit 7 enables manual power control
// - Bits 6-0 mask blocks, only while overriding
// - Bit 2 holds receiver-detect machine in reset
// - Detection disabled means no PCIe receiver handshake
// - Power-down pin places device in standby
// - Force bit bypasses machine, reports valid termination
`timescale 1ns/1ps
module redriver_power_and_rxdetect_ctrl
    import redriver_ctrl_pkg::*;
#(
    parameter int NUM_CH = 4,
    parameter logic [6:0] SLAVE_ADDR = DEFAULT_SLAVE_ADDR
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic power_down_pin,
    input wire logic [1:0] rxdet_strap_level,
    output logic standby,
    output chan_ctl_t [NUM_CH-1:0] chan_ctl
);

    if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_num_ch
        $error("NUM_CH must be 1 to 4");
    end

    // Pin synchronisers: a change counts once stages two and three agree
    pins_t s1, s2, s3, filt;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // Idle levels, so no false scl or sda edge follows reset
            s1 <= PINS_IDLE;
            s2 <= PINS_IDLE;
            s3 <= PINS_IDLE;
            filt <= PINS_IDLE;
        end else begin
            s1 <= {rxdet_strap_level, power_down_pin, scl_in, sda_in};
            s2 <= s1;
            s3 <= s2;
            filt <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
        end
    end

    logic scl_d, sda_d;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= filt.scl;
            sda_d <= filt.sda;
        end
    end

    logic scl_rise, scl_fall, start_cond, stop_cond;
    assign scl_rise = filt.scl & ~scl_d;
    assign scl_fall = ~filt.scl & scl_d;
    assign start_cond = filt.scl & scl_d & sda_d & ~filt.sda;
    assign stop_cond = filt.scl & scl_d & ~sda_d & filt.sda;

    // Strap is caught once, after the synchroniser has refilled from the pin
    logic strap_taken;
    logic [1:0] strap_level;
    logic [3:0] sync_fill;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_taken <= 1'b0;
            strap_level <= STRAP_LEVEL_L0;
            sync_fill <= 4'h0;
        end else begin
            sync_fill <= {sync_fill[2:0], 1'b1};
            if (!strap_taken && sync_fill[3]) begin
                strap_taken <= 1'b1;
                strap_level <= filt.strap;
            end
        end
    end

    // Per-channel register copies
    logic [7:0] pwr_ovr [NUM_CH];
    logic [7:0] rxdet_rst [NUM_CH];
    logic [2:0] rxdet_ctl [NUM_CH];

    function automatic logic chan_hit(input logic [7:0] a, input logic [4:0] ofs);
        chan_hit = (a[7] == 1'b0) && (int'(a[6:CHAN_SEL_LSB]) < NUM_CH)
            && (a[CHAN_OFS_BITS-1:0] == ofs);
    endfunction : chan_hit

    function automatic logic [7:0] read_reg(input logic [7:0] a,
            input logic [7:0] po [NUM_CH], input logic [7:0] rr [NUM_CH],
            input logic [2:0] rc [NUM_CH]);
        logic [1:0] ch;
        ch = a[6:CHAN_SEL_LSB];
        if (chan_hit(a, OFS_POWER_OVERRIDE)) begin
            read_reg = po[ch];
        end else if (chan_hit(a, OFS_RXDET_RESET)) begin
            read_reg = rr[ch] & RXDET_RESET_WMASK;
        end else if (chan_hit(a, OFS_RXDET_CTRL)) begin
            read_reg = {5'h00, rc[ch]};
        end else begin
            read_reg = UNMAPPED_READ;
        end
    endfunction : read_reg

    // Serial slave
    ser_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw_read;
    logic wr_stb;
    logic [7:0] wr_addr, wr_data;

    assign sda_out = 1'b0;

    // Byte at the pointer, loaded for the next read byte
    logic [7:0] rd_now;
    assign rd_now = read_reg(ptr, pwr_ovr, rxdet_rst, rxdet_ctl);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= SER_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            rw_read <= 1'b0;
            sda_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (start_cond) begin
                state <= SER_ADDR;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_cond) begin
                state <= SER_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    SER_ADDR, SER_PTR, SER_WDATA: begin
                        shreg <= {shreg[6:0], filt.sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    SER_RDATA: begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    SER_RDATA_ACK: begin
                        if (filt.sda) begin
                            state <= SER_WAIT_STOP;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state)
                    SER_ADDR: begin
                        if (bit_cnt == BITS_PER_BYTE) begin
                            bit_cnt <= 4'h0;
                            if (shreg[7:1] == SLAVE_ADDR) begin
                                rw_read <= shreg[0];
                                sda_oe <= 1'b1;
                                state <= SER_ADDR_ACK;
                            end else begin
                                state <= SER_WAIT_STOP;
                            end
                        end
                    end
                    SER_ADDR_ACK: begin
                        if (rw_read) begin
                            shreg <= rd_now;
                            sda_oe <= ~rd_now[7];
                            ptr <= ptr + 8'h01;
                            state <= SER_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state <= SER_PTR;
                        end
                    end
                    SER_PTR, SER_WDATA: begin
                        if (bit_cnt == BITS_PER_BYTE) begin
                            bit_cnt <= 4'h0;
                            sda_oe <= 1'b1;
                            if (state == SER_PTR) begin
                                ptr <= shreg;
                                state <= SER_PTR_ACK;
                            end else begin
                                wr_stb <= 1'b1;
                                wr_addr <= ptr;
                                wr_data <= shreg;
                                ptr <= ptr + 8'h01;
                                state <= SER_WDATA_ACK;
                            end
                        end
                    end
                    SER_PTR_ACK, SER_WDATA_ACK: begin
                        sda_oe <= 1'b0;
                        state <= SER_WDATA;
                    end
                    SER_RDATA: begin
                        if (bit_cnt == BITS_PER_BYTE) begin
                            bit_cnt <= 4'h0;
                            sda_oe <= 1'b0;
                            state <= SER_RDATA_ACK;
                        end else begin
                            shreg <= {shreg[6:0], 1'b0};
                            sda_oe <= ~shreg[6];
                        end
                    end
                    SER_RDATA_ACK: begin
                        shreg <= rd_now;
                        sda_oe <= ~rd_now[7];
                        ptr <= ptr + 8'h01;
                        state <= SER_RDATA;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Register writes; only the addressed channel's copy changes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                pwr_ovr[i] <= POWER_OVERRIDE_RESET;
                rxdet_rst[i] <= RXDET_RESET_RESET;
                rxdet_ctl[i] <= RXDET_CTRL_RESET;
            end
        end else if (wr_stb) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (int'(wr_addr[6:CHAN_SEL_LSB]) == i) begin
                    if (chan_hit(wr_addr, OFS_POWER_OVERRIDE)) begin
                        pwr_ovr[i] <= wr_data;
                    end
                    if (chan_hit(wr_addr, OFS_RXDET_RESET)) begin
                        rxdet_rst[i] <= wr_data & RXDET_RESET_WMASK;
                    end
                    if (chan_hit(wr_addr, OFS_RXDET_CTRL)) begin
                        rxdet_ctl[i] <= wr_data[2:0];
                    end
                end
            end
        end
    end

    // Channel controls
    logic agnostic;
    assign agnostic = (strap_level == STRAP_LEVEL_L0);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            standby <= 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
                chan_ctl[i] <= '0;
            end
        end else begin
            standby <= filt.pd;
            for (int i = 0; i < NUM_CH; i++) begin
                if (filt.pd) begin
                    chan_ctl[i].block_enable <= ALL_BLOCKS_OFF;
                end else if (pwr_ovr[i][OVR_ENABLE_BIT]) begin
                    chan_ctl[i].block_enable <= pwr_ovr[i][BLOCK_MASK_BITS-1:0];
                end else begin
                    chan_ctl[i].block_enable <= ALL_BLOCKS_ON;
                end
                chan_ctl[i].rxdet_fsm_reset <= rxdet_rst[i][RXDET_RST_BIT] | agnostic;
                chan_ctl[i].rxdet_enable <= ~agnostic & ~rxdet_rst[i][RXDET_RST_BIT];
                chan_ctl[i].rxdet_force_valid <= rxdet_ctl[i][RXDET_FORCE_BIT];
            end
        end
    end

endmodule : redriver_power_and_rxdetect_ctrl

// ===== common/redriver_ctrl_pkg.sv
// Constants and types for the per-channel power override and receiver-detect control block.
// Assumes a single management clock and an SMBus/I2C host on the serial pins.
package redriver_ctrl_pkg;

    // Channel register window: channel n starts at n * CHAN_STRIDE
    localparam logic [7:0] CHAN_STRIDE = 8'h20;
    localparam int CHAN_SEL_LSB = 5;
    localparam int CHAN_OFS_BITS = 5;

    // Register offsets inside a channel window
    localparam logic [4:0] OFS_RXDET_CTRL = 5'h04;
    localparam logic [4:0] OFS_POWER_OVERRIDE = 5'h05;
    localparam logic [4:0] OFS_RXDET_RESET = 5'h0a;

    // Field positions
    localparam int OVR_ENABLE_BIT = 7;
    localparam int BLOCK_MASK_BITS = 7;
    localparam int RXDET_RST_BIT = 2;
    localparam int RXDET_FORCE_BIT = 2;

    // Values after reset
    localparam logic [7:0] POWER_OVERRIDE_RESET = 8'h7f;
    localparam logic [7:0] RXDET_RESET_RESET = 8'h00;
    localparam logic [2:0] RXDET_CTRL_RESET = 3'h0;
    localparam logic [6:0] ALL_BLOCKS_ON = 7'h7f;
    localparam logic [6:0] ALL_BLOCKS_OFF = 7'h00;

    // Writable bits of the receiver-detect reset register
    localparam logic [7:0] RXDET_RESET_WMASK = 8'h07;

    // Strap level that selects protocol-agnostic operation
    localparam logic [1:0] STRAP_LEVEL_L0 = 2'h0;

    // Read value of an unmapped register
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Serial slave address; value is arbitrary
    localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h2a;

    // Bits per serial byte
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [3:0] {
        SER_IDLE,
        SER_ADDR,
        SER_ADDR_ACK,
        SER_PTR,
        SER_PTR_ACK,
        SER_WDATA,
        SER_WDATA_ACK,
        SER_RDATA,
        SER_RDATA_ACK,
        SER_WAIT_STOP
    } ser_state_t;

    // Controls driven to one channel's analog blocks
    typedef struct packed {
        logic [6:0] block_enable;
        logic rxdet_fsm_reset;
        logic rxdet_enable;
        logic rxdet_force_valid;
    } chan_ctl_t;

    // Synchronised pins
    typedef struct packed {
        logic [1:0] strap;
        logic pd;
        logic scl;
        logic sda;
    } pins_t;

    // Idle pin levels loaded into the synchronisers by reset
    localparam pins_t PINS_IDLE = '{strap: STRAP_LEVEL_L0, pd: 1'b0, scl: 1'b1, sda: 1'b1};

endpackage : redriver_ctrl_pkg

// ===== bench/i2c_host_model.sv
// Behavioural serial management host driving scl and a wired sda line.
// Assumes the device pulls sda low via dev_pull; a pull-up holds the line high otherwise.
`timescale 1ns/1ps
module i2c_host_model
    import redriver_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic dev_pull,
    output logic scl,
    output logic sda
);
    logic drv = 1'b1;
    logic [6:0] dev = DEFAULT_SLAVE_ADDR;
    initial scl = 1'b1;
    // Released line reads high through the pull-up
    assign sda = drv & ~dev_pull;
    task automatic hw(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : hw
    // Start when a is 1, stop when a is 0
    task automatic cond(input logic a);
        hw(2);
        drv = a;
        hw(6);
        scl = 1'b1;
        hw(8);
        drv = ~a;
        hw(8);
        if (a) scl = 1'b0;
    endtask : cond
    task automatic clk_bit(input logic b, output logic s);
        hw(2);
        drv = b;
        hw(6);
        scl = 1'b1;
        hw(4);
        s = sda;
        hw(4);
        scl = 1'b0;
    endtask : clk_bit
    task automatic xbyte(input logic [7:0] b, output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
            r[i] = s;
        end
        clk_bit(1'b1, s);
        ack = ~s;
    endtask : xbyte
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2;
        cond(1'b1);
        xbyte({dev, 1'b0}, r, k0);
        xbyte(a, r, k1);
        xbyte(d, r, k2);
        cond(1'b0);
        ok = k0 & k1 & k2;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic k;
        cond(1'b1);
        xbyte({dev, 1'b0}, d, k);
        xbyte(a, d, k);
        cond(1'b1);
        xbyte({dev, 1'b1}, d, k);
        xbyte(8'hff, d, k);
        cond(1'b0);
    endtask : rd
endmodule : i2c_host_model

// ===== bench/redriver_power_and_rxdetect_ctrl_asserts.sv
// Port-level checker for the redriver control block, bound to its top module.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/1ps
module redriver_ctrl_checker
    import redriver_ctrl_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic power_down_pin,
    input wire logic [1:0] rxdet_strap_level,
    input wire logic standby,
    input wire chan_ctl_t [NUM_CH-1:0] chan_ctl
);
    logic [NUM_CH-1:0] en_v;
    logic [NUM_CH-1:0] rst_v;
    logic any_on;
    logic scl_d;
    logic [3:0] since_fall;
    always_comb begin
        any_on = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            en_v[i] = chan_ctl[i].rxdet_enable;
            rst_v[i] = chan_ctl[i].rxdet_fsm_reset;
            any_on = any_on | (|chan_ctl[i].block_enable);
        end
    end
    // Cycles since the last falling scl pin edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_d <= 1'b1;
            since_fall <= 4'hf;
        end else begin
            scl_d <= scl_in;
            if (scl_d && !scl_in) since_fall <= 4'h0;
            else if (since_fall != 4'hf) since_fall <= since_fall + 4'h1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    reset_quiet_a: assert property (disable iff (1'b0)
        !nrst |-> !sda_oe && !standby && chan_ctl == '0) else $error("output active in reset");
    sda_drain_a: assert property (sda_out == 1'b0) else $error("sda driven high");
    standby_on_a: assert property (power_down_pin [*8] |-> standby) else $error("no standby");
    standby_off_a: assert property (!power_down_pin [*8] |-> !standby) else $error("standby");
    blocks_off_a: assert property (power_down_pin [*8] |-> !any_on) else $error("block on");
    rxdet_excl_a: assert property ($past(nrst, 2) |-> en_v == ~rst_v) else $error("rxdet");
    agnostic_mode_a: assert property ((rxdet_strap_level == STRAP_LEVEL_L0) [*8]
        |-> en_v == '0) else $error("detection on in agnostic mode");
    oe_timing_a: assert property ($changed(sda_oe) |-> since_fall inside {[4'h1:4'h9]})
        else $error("sda drive change not after scl fall");
endmodule : redriver_ctrl_checker
bind redriver_power_and_rxdetect_ctrl redriver_ctrl_checker #(.NUM_CH(NUM_CH)) checker_inst (
    .clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .power_down_pin(power_down_pin), .rxdet_strap_level(rxdet_strap_level),
    .standby(standby), .chan_ctl(chan_ctl));

// ===== bench/redriver_power_and_rxdetect_ctrl_tb_top.sv
// Self-checking bench: register accesses over the serial host model, pin tests.
// Assumes the host model and checker files are compiled before this one.
`timescale 1ns/1ps
module redriver_power_and_rxdetect_ctrl_tb_top
    import redriver_ctrl_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b1;
    logic pd = 1'b0;
    logic [1:0] strap = STRAP_LEVEL_L0;
    logic scl, sda, sda_oe, standby, ok;
    logic [7:0] rv;
    chan_ctl_t [3:0] cc;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    redriver_power_and_rxdetect_ctrl #(.NUM_CH(4)) redriver_power_and_rxdetect_ctrl_inst (
        .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .power_down_pin(pd), .rxdet_strap_level(strap), .standby(standby), .chan_ctl(cc));
    i2c_host_model i2c_host_model_inst (.clk(clk), .dev_pull(sda_oe), .scl(scl), .sda(sda));
    task automatic close_out();
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk
    task automatic do_reset(input logic [1:0] s);
        nrst = 1'b0;
        strap = s;
        wait_clk(16);
        nrst = 1'b1;
        wait_clk(8);
    endtask : do_reset
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i2c_host_model_inst.wr(a, d, ok);
        chk(ok, 1'b1);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        i2c_host_model_inst.rd(a, rv);
        chk(rv, e);
    endtask : rdc
    initial begin
        // Reset falls after time zero, so the design sees a real falling edge
        #1;
        do_reset(STRAP_LEVEL_L0);
        for (int c = 0; c < 4; c++) begin
            chk(cc[c], {ALL_BLOCKS_ON, 3'h4});
            rdc(8'(c * 32 + 5), 8'h7f);
            rdc(8'(c * 32 + 10), 8'h00);
        end
        wr(8'h25, 8'h80);
        chk(cc[1].block_enable, ALL_BLOCKS_OFF);
        chk(cc[0].block_enable, ALL_BLOCKS_ON);
        wr(8'h25, 8'hd5);
        chk(cc[1].block_enable, 7'h55);
        pd = 1'b1;
        wait_clk(12);
        chk(standby, 1'b1);
        for (int c = 0; c < 4; c++) chk(cc[c].block_enable, ALL_BLOCKS_OFF);
        pd = 1'b0;
        wait_clk(12);
        chk(standby, 1'b0);
        chk(cc[1].block_enable, 7'h55);
        wr(8'h25, 8'h2a);
        chk(cc[1].block_enable, ALL_BLOCKS_ON);
        rdc(8'h25, 8'h2a);
        rdc(8'h06, 8'h00);
        rdc(8'h85, 8'h00);
        i2c_host_model_inst.dev = 7'h11;
        i2c_host_model_inst.wr(8'h25, 8'h00, ok);
        chk(ok, 1'b0);
        i2c_host_model_inst.dev = DEFAULT_SLAVE_ADDR;
        rdc(8'h25, 8'h2a);
        do_reset(2'h2);
        chk(cc[1].block_enable, ALL_BLOCKS_ON);
        chk(cc[2], {ALL_BLOCKS_ON, 3'h2});
        wr(8'h4a, 8'h04);
        chk(cc[2], {ALL_BLOCKS_ON, 3'h4});
        chk(cc[1], {ALL_BLOCKS_ON, 3'h2});
        wr(8'h4a, 8'hff);
        rdc(8'h4a, 8'h07);
        wr(8'h4a, 8'h00);
        chk(cc[2], {ALL_BLOCKS_ON, 3'h2});
        wr(8'h64, 8'h04);
        chk(cc[3].rxdet_force_valid, 1'b1);
        chk(cc[2].rxdet_force_valid, 1'b0);
        rdc(8'h64, 8'h04);
        close_out();
    end
endmodule : redriver_power_and_rxdetect_ctrl_tb_top
